// ==== logic/mdsc_act_det.sv ====
/*
 Activity detector: per-axis threshold compare and the sustained-motion
 timer. Assumes samples are stable while valid and the clock enable comes
 from the control bank.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsc_act_det (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Setup
   input wire logic [2:0] axis_mask,
   input wire logic [10:0] threshold,
   input wire logic [23:0] time_steps,
   input wire logic armed,
   // Samples
   input wire mdsc_pkg::mdsc_sample_s sample,
   // Result
   output logic hit
);
   import mdsc_pkg::*;
   logic [MDSC_AXES-1:0] over;
   logic [11:0] ax [MDSC_AXES];
   logic [15:0] tick_r, tick_nxt;
   logic [23:0] cnt_r, cnt_nxt;
   logic any_over;

   assign ax[0] = sample.x;
   assign ax[1] = sample.y;
   assign ax[2] = sample.z;

   genvar g;
   generate
      for (g = 0; g < MDSC_AXES; g++) begin : g_axis
         logic [11:0] mag;
         assign mag = ax[g][11] ? 12'(-ax[g]) : ax[g];
         assign over[g] = axis_mask[g] &&
            ({mag, 4'h0} > {5'h00, threshold});
      end
   endgenerate
   assign any_over = |over;

   always_comb begin
      tick_nxt = tick_r;
      cnt_nxt = cnt_r;
      if (!any_over || !armed) begin
         tick_nxt = '0;
         cnt_nxt = '0;
      end else if (tick_r == MDSC_STEP_LAST) begin
         tick_nxt = '0;
         if (cnt_r < time_steps)
            cnt_nxt = cnt_r + 24'h00_0001;
      end else begin
         tick_nxt = tick_r + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tick_r <= '0;
         cnt_r <= '0;
      end else if (clk_en) begin
         tick_r <= tick_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign hit = clk_en && armed && any_over && (cnt_r >= time_steps);
endmodule
`default_nettype wire

// ==== logic/mdsc_ctrl.sv ====
/*
 Control bank for motion detection, density stream polarity and self-test.
 Assumes the serial control interface presents one decoded byte access per
 cycle, and that the stillness detector, filter and serializer sit outside.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsc_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Detector inputs
   input wire mdsc_pkg::mdsc_sample_s raw_sample,
   input wire mdsc_pkg::mdsc_sample_s hpf_sample,
   input wire logic [10:0] motion_threshold,
   input wire logic [23:0] activity_time,
   input wire logic still_hit,
   input wire logic act_int_clear,
   input wire logic still_int_clear,
   // Density stream
   input wire logic density_bit,
   output logic density_negative,
   // Detector outputs
   output mdsc_pkg::mdsc_sample_s det_sample,
   output logic [2:0] detect_axis_mask,
   output logic still_enable,
   output logic still_referenced,
   output logic still_armed,
   output logic motion_referenced,
   output logic act_clk_en,
   output logic act_event,
   output logic still_event,
   output logic act_int,
   output logic still_int,
   // Self-test
   output logic selftest_enable,
   output logic selftest_drive,
   output logic selftest_polarity
);
   import mdsc_pkg::*;
   mdsc_motion_s motion_r, motion_nxt;
   mdsc_selftest_s st_r, st_nxt;
   logic act_int_r, act_int_nxt, still_int_r, still_int_nxt;
   logic last_act_r, last_act_nxt;
   logic motion_en, act_armed, act_hit, linked, looped;

   always_comb begin
      motion_nxt = motion_r;
      st_nxt = st_r;
      if (reg_wr && reg_addr == MDSC_ADDR_MOTION)
         motion_nxt = mdsc_motion_s'(reg_wdata);
      if (reg_wr && reg_addr == MDSC_ADDR_SELFTEST)
         st_nxt = mdsc_selftest_s'(reg_wdata & MDSC_SELFTEST_WMASK);
   end

   always_comb begin
      case (reg_addr)
         MDSC_ADDR_MOTION: reg_rdata = motion_r;
         MDSC_ADDR_SELFTEST: reg_rdata = st_r;
         default: reg_rdata = '0;
      endcase
   end

   assign motion_en = motion_r.motion_mode[0];
   assign motion_referenced = motion_r.motion_mode == MDSC_MODE_REF;
   assign still_enable = motion_r.still_mode[0];
   assign still_referenced = motion_r.still_mode == MDSC_MODE_REF;
   assign act_clk_en = motion_en;
   assign det_sample = motion_r.hpf ? hpf_sample : raw_sample;
   assign detect_axis_mask = st_r.axis_mask;
   assign selftest_enable = st_r.st_en;
   assign selftest_drive = st_r.st_drive;
   assign selftest_polarity = st_r.st_pol;

   // host enables both first; modes assume it
   assign linked = motion_r.chain == MDSC_CHAIN_LINK;
   assign looped = motion_r.chain == MDSC_CHAIN_LOOP;

   always_comb begin
      act_armed = 1'b0;
      still_armed = 1'b0;
      case ({linked, looped})
         2'b10: begin
            act_armed = !last_act_r && !still_int_r;
            still_armed = last_act_r && !act_int_r;
         end
         2'b01: begin
            act_armed = !last_act_r;
            still_armed = last_act_r;
         end
         default: begin
            act_armed = !act_int_r;
            still_armed = !still_int_r;
         end
      endcase
      act_armed = act_armed && motion_en;
      still_armed = still_armed && still_enable;
   end

   assign act_event = act_hit;
   assign still_event = still_hit && still_armed;

   always_comb begin
      last_act_nxt = last_act_r;
      if (act_event)
         last_act_nxt = 1'b1;
      else if (still_event)
         last_act_nxt = 1'b0;
      // Event wins over a clear in the same cycle
      act_int_nxt = act_event || (act_int_r && !act_int_clear);
      still_int_nxt = still_event || (still_int_r && !still_int_clear);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         motion_r <= mdsc_motion_s'(MDSC_RESET_VAL);
         st_r <= mdsc_selftest_s'(MDSC_RESET_VAL);
         act_int_r <= 1'b0;
         still_int_r <= 1'b0;
         last_act_r <= 1'b0;
         density_negative <= 1'b0;
      end else begin
         motion_r <= motion_nxt;
         st_r <= st_nxt;
         act_int_r <= act_int_nxt;
         still_int_r <= still_int_nxt;
         last_act_r <= last_act_nxt;
         density_negative <= density_bit ^ motion_r.invert;
      end
   end

   assign act_int = act_int_r;
   assign still_int = still_int_r;

   mdsc_act_det u_act (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(act_clk_en),
      .axis_mask(st_r.axis_mask),
      .threshold(motion_threshold),
      .time_steps(activity_time),
      .armed(act_armed),
      .sample(det_sample),
      .hit(act_hit)
   );

   a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
      st_r.rsvd == 2'b00) else $error("reserved bits set");
   a_reset_zero: assert property (@(posedge clk)
      $past(sys_rst) |-> motion_r == 8'h00 && st_r == 8'h00)
      else $error("reset not zero");
   a_invert_map: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> density_negative ==
      ($past(density_bit) ^ $past(motion_r.invert)))
      else $error("polarity wrong");
   a_hpf_select: assert property (@(posedge clk) disable iff (sys_rst)
      det_sample == (motion_r.hpf ? hpf_sample : raw_sample))
      else $error("sample source wrong");
   a_act_gated: assert property (@(posedge clk) disable iff (sys_rst)
      motion_r.motion_mode[0] == 1'b0 |-> !act_clk_en && !act_event)
      else $error("activity ran while off");
   a_indep_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (!linked && !looped && act_int_r) |-> !act_event)
      else $error("activity before own clear");
   a_link_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (linked && still_int_r) |-> !act_event)
      else $error("linked activity before clear");
   a_loop_alt: assert property (@(posedge clk) disable iff (sys_rst)
      (looped && act_event) |=> !act_event until still_event)
      else $error("loop did not alternate");
   a_still_dec: assert property (@(posedge clk) disable iff (sys_rst)
      still_enable == (motion_r.still_mode inside {2'b01, 2'b11}))
      else $error("stillness decode wrong");
   a_st_write: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && reg_addr == MDSC_ADDR_SELFTEST |=>
      {selftest_enable, selftest_drive, selftest_polarity, detect_axis_mask}
      == {$past(reg_wdata[7:5]), $past(reg_wdata[2:0])})
      else $error("self-test write lost");
endmodule
`default_nettype wire

// ==== logic/mdsc_pkg.sv ====
/*
 Constants, field layouts and types for the motion detect and self-test
 control bank. Assumes a byte-wide register port from the serial control
 interface, already decoded into write strobes, and one core clock.
*/
// Function
// - Stream invert at 0 maps bit 0 to positive and bit 1 to negative full scale, 1 swaps it.
// - The highpass select bit chooses raw or high-pass samples for both detectors.
// - Chain modes 00 and 10 run the detectors independently, each rearmed by its own clear.
// - Chain mode 01 links the detectors, each rearmed by the other's clear.
// - Chain mode 11 loops the detectors with no wait for any clear.
// - Stillness mode 01 is absolute, 11 referenced, 00 and 10 off.
// - Motion mode 01 is absolute, 11 referenced, 00 and 10 off.
// - With motion detection off the activity block gets no clock enable.
// - Self-test enable places the part in self-test mode.
// - Self-test drive applies the electrostatic force.
// - Self-test polarity reverses the force direction.
// - The axis mask enables X, Y and Z with one bit each.
// - Both registers reset to zero.
// - Activity compares abs of a 12-bit sample times 16 with the 11-bit threshold.
// - Activity needs an enabled axis above threshold for the timed count of 500 us steps.
package mdsc_pkg;
   localparam logic [7:0] MDSC_ADDR_MOTION = 8'h37;
   localparam logic [7:0] MDSC_ADDR_SELFTEST = 8'h38;
   localparam logic [7:0] MDSC_RESET_VAL = 8'h00;
   localparam logic [7:0] MDSC_SELFTEST_WMASK = 8'hE7;
   localparam int MDSC_BIT_INVERT = 7;
   localparam int MDSC_BIT_HPF = 6;
   localparam int MDSC_BIT_ST_EN = 7;
   localparam int MDSC_BIT_ST_DRIVE = 6;
   localparam int MDSC_BIT_ST_POL = 5;
   localparam logic [1:0] MDSC_MODE_ABS = 2'b01;
   localparam logic [1:0] MDSC_MODE_REF = 2'b11;
   localparam logic [1:0] MDSC_CHAIN_LINK = 2'b01;
   localparam logic [1:0] MDSC_CHAIN_LOOP = 2'b11;
   localparam int MDSC_STEP_NS = 500000;
   localparam int MDSC_CLK_NS = 8;
   localparam int MDSC_STEP_CYC = MDSC_STEP_NS / MDSC_CLK_NS;
   localparam logic [15:0] MDSC_STEP_LAST = 16'(MDSC_STEP_CYC - 1);
   localparam int MDSC_AXES = 3;

   typedef struct packed {
      logic invert;
      logic hpf;
      logic [1:0] chain;
      logic [1:0] still_mode;
      logic [1:0] motion_mode;
   } mdsc_motion_s;

   typedef struct packed {
      logic st_en;
      logic st_drive;
      logic st_pol;
      logic [1:0] rsvd;
      logic [2:0] axis_mask;
   } mdsc_selftest_s;

   typedef struct packed {
      logic signed [11:0] x;
      logic signed [11:0] y;
      logic signed [11:0] z;
   } mdsc_sample_s;
endpackage

// ==== tb/mdsc_host_model.sv ====
/*
 Host side of the register port: byte writes and reads.
 Assumes one write strobe per cycle, driven on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mdsc_host_model (
   // Bus
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wr = 1'b1;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      // Released data shows its inverse so stale values are never reused
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      #1 d = reg_rdata;
   endtask
   task automatic chain_on(input logic [1:0] ch);
      wr(8'h37, 8'h05);
      wr(8'h37, {2'b00, ch, 4'b0101});
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the control bank.
 Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mdsc_pkg::*;
   logic clk, sys_rst, density_bit, act_int_clear, act_int;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, m;
   logic reg_wr, density_negative, still_enable, still_referenced;
   logic motion_referenced, act_clk_en, st_en, st_drive, st_pol;
   logic [2:0] mask;
   logic sh, scl, still_int;
   logic [23:0] act_time;
   logic [10:0] thr;
   logic [63:0] r64;
   mdsc_sample_s raw, hpf, det;
   int fail_count, comparisons, seed;
   mdsc_host_model i_mdsc_host_model (.clk(clk), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   mdsc_ctrl i_mdsc_ctrl (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .raw_sample(raw), .hpf_sample(hpf),
      .motion_threshold(thr), .activity_time(act_time),
      .still_hit(sh), .act_int_clear(act_int_clear),
      .still_int_clear(scl), .density_bit(density_bit),
      .density_negative(density_negative), .det_sample(det),
      .detect_axis_mask(mask), .still_enable(still_enable),
      .still_referenced(still_referenced), .still_armed(),
      .motion_referenced(motion_referenced), .act_clk_en(act_clk_en),
      .act_event(), .still_event(), .act_int(act_int),
      .still_int(still_int),
      .selftest_enable(st_en), .selftest_drive(st_drive),
      .selftest_polarity(st_pol));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string n, input logic [35:0] e,
         input logic [35:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Activity flag seen within eight cycles
   task automatic wait_int(input logic e);
      logic s;
      s = 1'b0;
      repeat (8) begin
         @(negedge clk);
         s = s | act_int;
      end
      chk("act_int", 36'(e), 36'(s));
   endtask
   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      // One full activity step plus the short scenarios
      #720000;
      fail_count++;
      finish_test();
   end
   initial begin
      seed = 32'hc176_41ef;
      sys_rst = 1'b1;
      density_bit = 1'b0;
      act_int_clear = 1'b0;
      sh = 1'b0;
      scl = 1'b0;
      act_time = 24'h00_0000;
      thr = 11'h080;
      raw = '0;
      hpf = '0;
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      i_mdsc_host_model.rd(8'h37, d);
      chk("reset 37", 36'h0, 36'(d));
      i_mdsc_host_model.rd(8'h38, d);
      chk("reset 38", 36'h0, 36'(d));
      for (int i = 0; i < 24; i++) begin
         m = 8'($random(seed));
         if (i < 4) m[1:0] = 2'(i);
         if (i < 4) m[3:2] = 2'(i);
         r64 = {$random(seed), $random(seed)};
         raw = r64[35:0];
         r64 = {$random(seed), $random(seed)};
         hpf = r64[35:0];
         i_mdsc_host_model.wr(8'h37, m);
         density_bit = 1'($random(seed));
         i_mdsc_host_model.rd(8'h37, d);
         chk("rd 37", 36'(m), 36'(d));
         chk("density", 36'(density_bit ^ m[7]),
            36'(density_negative));
         chk("det", m[6] ? hpf : raw, det);
         chk("still_en", 36'(m[2]), 36'(still_enable));
         chk("still_ref", 36'(m[3:2] == 2'b11),
            36'(still_referenced));
         chk("mot_ref", 36'(m[1:0] == 2'b11), 36'(motion_referenced));
         chk("clk_en", 36'(m[0]), 36'(act_clk_en));
         m = 8'($random(seed));
         i_mdsc_host_model.wr(8'h38, m);
         i_mdsc_host_model.wr(8'($random(seed)) | 8'h40, 8'hff);
         i_mdsc_host_model.rd(8'h38, d);
         chk("rd 38", 36'(m & 8'he7), 36'(d));
         chk("st", 36'(m[7:5]),
            36'({st_en, st_drive, st_pol}));
         chk("mask", 36'(m[2:0]), 36'(mask));
      end
      i_mdsc_host_model.chain_on(2'b11);
      i_mdsc_host_model.rd(8'h37, d);
      chk("chain", 36'h35, 36'(d));
      i_mdsc_host_model.wr(8'h38, 8'h01);
      i_mdsc_host_model.wr(8'h37, 8'h00);
      act_int_clear = 1'b1;
      hpf = '0;
      raw = '0;
      raw.x = -12'sd9;
      @(negedge clk);
      act_int_clear = 1'b0;
      wait_int(1'b0);
      raw.x = -12'sd8;
      i_mdsc_host_model.wr(8'h37, 8'h01);
      wait_int(1'b0);
      raw.x = 12'sd0;
      raw.y = 12'sd200;
      wait_int(1'b0);
      raw.x = -12'sd9;
      wait_int(1'b1);
      raw.x = 12'sd0;
      wait_int(1'b1);
      act_int_clear = 1'b1;
      @(negedge clk);
      act_int_clear = 1'b0;
      @(negedge clk);
      chk("cleared", 36'h0, 36'(act_int));
      // One activity step must pass before the flag rises
      act_time = 24'h00_0001;
      raw.x = -12'sd9;
      wait_int(1'b0);
      repeat (62500) @(negedge clk);
      wait_int(1'b1);
      raw.x = 12'sd0;
      // Linked: stillness waits for the activity flag to clear
      i_mdsc_host_model.wr(8'h37, 8'h15);
      sh = 1'b1;
      @(negedge clk);
      @(negedge clk);
      chk("still held", 36'h0, 36'(still_int));
      act_int_clear = 1'b1;
      @(negedge clk);
      act_int_clear = 1'b0;
      @(negedge clk);
      chk("still set", 36'h1, 36'(still_int));
      sh = 1'b0;
      scl = 1'b1;
      @(negedge clk);
      scl = 1'b0;
      // Reset again in mid-run
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      i_mdsc_host_model.rd(8'h37, d);
      chk("rerst 37", 36'h0, 36'(d));
      i_mdsc_host_model.rd(8'h38, d);
      chk("rerst 38", 36'h0, 36'(d));
      chk("rerst int", 36'h0, 36'({act_int, still_int}));
      finish_test();
   end
endmodule
`default_nettype wire
